// File: verilog/eisl_pkg.sv
// Package for the ethernet interrupt status latch: offsets, bit positions, types
package eisl_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_INTERRUPT_STATUS = 8'h58;
    localparam logic [7:0] ADDR_SOFTWARE_IRQ_CTL = 8'h5c;
    localparam logic [7:0] ADDR_BYTE_TEST        = 8'h64;
    localparam logic [7:0] ADDR_WAKE_STATUS      = 8'h80;

    // Flag bit positions in interrupt_status
    localparam int BIT_SOFTWARE_IRQ      = 31;
    localparam int BIT_TRANSMIT_HALTED   = 25;
    localparam int BIT_RECEIVE_HALTED    = 24;
    localparam int BIT_DROP_HALFWAY      = 23;
    localparam int BIT_TX_BUFFER_DONE    = 21;
    localparam int BIT_RECEIVE_DMA       = 20;
    localparam int BIT_TIMER_WRAP        = 19;
    localparam int BIT_TRANSCEIVER       = 18;
    localparam int BIT_POWER_EVENT       = 17;
    localparam int BIT_TX_STATUS_OVF     = 16;
    localparam int BIT_RX_WATCHDOG       = 15;
    localparam int BIT_RX_ERROR          = 14;
    localparam int BIT_TX_ERROR          = 13;
    localparam int BIT_TX_UNDERRUN       = 11;
    localparam int BIT_TX_OVERRUN        = 10;
    localparam int BIT_TX_SPACE          = 9;
    localparam int BIT_TX_STATUS_FULL    = 8;
    localparam int BIT_TX_STATUS_LEVEL   = 7;
    localparam int BIT_RX_FRAME_DROPPED  = 6;
    localparam int BIT_RX_DATA_LEVEL     = 5;
    localparam int BIT_RX_STATUS_FULL    = 4;
    localparam int BIT_RX_STATUS_LEVEL   = 3;

    // Flags that latch and clear by write of one (all but bit 18 and reserved)
    localparam logic [31:0] STICKY_MASK  = 32'h83bbeff8 | 32'h00000007;
    // Bit of the control register that enables the software interrupt
    localparam int BIT_SW_ENABLE         = 31;
    localparam logic [31:0] RESET_FLAGS  = 32'h00000000;
    // Read value of the byte order test register
    localparam logic [31:0] BYTE_TEST_VALUE = 32'h87654321;
    // Drop counter halfway crossing and timer wrap values
    localparam logic [31:0] DROP_BELOW_HALF = 32'h7fffffff;
    localparam logic [31:0] DROP_AT_HALF    = 32'h80000000;
    localparam logic [15:0] TIMER_WRAP_VALUE = 16'hffff;
    localparam logic [15:0] TIMER_ZERO       = 16'h0000;

    // Single-cycle event strobes from the source units
    typedef struct packed {
        logic       transmit_halted;
        logic       receive_halted;
        logic       drop_count_step;
        logic [31:0] drop_count_prev;
        logic       tx_buffer_done;
        logic       receive_dma_done;
        logic       timer_step;
        logic [15:0] timer_prev;
        logic       power_event;
        logic       tx_status_overflow;
        logic       rx_long_packet;
        logic       rx_error;
        logic       tx_error;
        logic       tx_underrun;
        logic       tx_overrun;
        logic       tx_space_above;
        logic       tx_status_full;
        logic       tx_status_level;
        logic       rx_frame_dropped;
        logic       rx_data_level;
        logic       rx_status_full;
        logic       rx_status_level;
        logic [2:0] general_pin_irq;
    } eisl_events_t;

    // Whole state of the block
    typedef struct packed {
        logic [31:0] flags;
        logic        software_irq_enable;
        logic        awake;
        logic [31:0] prdata;
    } eisl_state_t;

endpackage

// File: verilog/eisl_status_latch.sv
// Interrupt status latch with APB register access
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Writing one clears a latched flag; writing zero leaves it.
// - Bit 31 sets while the software interrupt enable is set; write one clears only with the enable off.
// - Bit 25 sets when a requested transmit stop has halted the transmitter.
// - Bit 24 sets when the receive engine halts.
// - Bit 23 sets when the drop counter steps 7fffffff to 80000000.
// - Bit 21 sets when a completion-marked buffer is loaded into transmit FIFO.
// - Bit 20 sets when the programmed receive DMA dword count is read out.
// - Bit 19 sets when the general timer wraps from zero to ffff.
// - Bit 18 shows the transceiver event live; writes have no effect.
// - Bit 17 sets on power events regardless of wake pin; write one clears.
// - The power event flag bypasses the interrupt hold-off interval.
// - Bit 16 sets when the transmit status FIFO overflows.
// - Bit 15 sets when a packet over 2048 bytes is received.
// - Bit 14 sets on any receive engine error.
// - Bit 13 sets on any transmit engine error.
// - Bit 10 sets on write to full transmit FIFO; bit 11 on underrun.
// - Bit 9 sets when transmit FIFO free space exceeds the threshold.
// - Bit 7 sets at transmit status level; bit 8 when it is full.
// - Bit 6 sets every time an incoming frame is dropped.
// - Bit 5 at receive data level; bits 3 and 4 for receive status.
// - Bits 2 to 0 latch the three general pin interrupts; write one clears.
// - Flags latch regardless of any enable mask.
module eisl_status_latch (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic                       pslverr,
    output logic [31:0]                prdata,
    input  wire eisl_pkg::eisl_events_t events,
    input  wire logic                  transceiver_event,
    output logic [31:0]                interrupt_status,
    output logic                       power_event_flag,
    output logic                       awake
);

    eisl_pkg::eisl_state_t state;
    eisl_pkg::eisl_state_t next_state;

    logic        wr_access;
    logic        rd_access;
    logic        rd_setup;
    logic        addr_mapped;
    logic [31:0] byte_mask;
    logic [31:0] set_vec;
    logic [31:0] clear_vec;
    logic [31:0] status_view;

    // APB decode; slave answers in the first access cycle
    assign wr_access   = psel && penable && pwrite;
    assign rd_access   = psel && penable && !pwrite;
    assign rd_setup    = psel && !penable && !pwrite;  // Read data captured here
    assign addr_mapped = (paddr == eisl_pkg::ADDR_INTERRUPT_STATUS)
                      || (paddr == eisl_pkg::ADDR_SOFTWARE_IRQ_CTL)
                      || (paddr == eisl_pkg::ADDR_BYTE_TEST)
                      || (paddr == eisl_pkg::ADDR_WAKE_STATUS);
    assign pready      = 1'b1;
    assign pslverr     = psel && penable && !addr_mapped;
    assign byte_mask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    // Event vector collecting each source into its flag position
    always_comb begin
        set_vec = 32'h00000000;
        set_vec[eisl_pkg::BIT_SOFTWARE_IRQ]     = state.software_irq_enable;
        set_vec[eisl_pkg::BIT_TRANSMIT_HALTED]  = events.transmit_halted;
        set_vec[eisl_pkg::BIT_RECEIVE_HALTED]   = events.receive_halted;
        set_vec[eisl_pkg::BIT_DROP_HALFWAY]     = events.drop_count_step
            && (events.drop_count_prev == eisl_pkg::DROP_BELOW_HALF);
        set_vec[eisl_pkg::BIT_TX_BUFFER_DONE]   = events.tx_buffer_done;
        set_vec[eisl_pkg::BIT_RECEIVE_DMA]      = events.receive_dma_done;
        set_vec[eisl_pkg::BIT_TIMER_WRAP]       = events.timer_step
            && (events.timer_prev == eisl_pkg::TIMER_ZERO);
        set_vec[eisl_pkg::BIT_POWER_EVENT]      = events.power_event;
        set_vec[eisl_pkg::BIT_TX_STATUS_OVF]    = events.tx_status_overflow;
        set_vec[eisl_pkg::BIT_RX_WATCHDOG]      = events.rx_long_packet;
        set_vec[eisl_pkg::BIT_RX_ERROR]         = events.rx_error;
        set_vec[eisl_pkg::BIT_TX_ERROR]         = events.tx_error;
        set_vec[eisl_pkg::BIT_TX_UNDERRUN]      = events.tx_underrun;
        set_vec[eisl_pkg::BIT_TX_OVERRUN]       = events.tx_overrun;
        set_vec[eisl_pkg::BIT_TX_SPACE]         = events.tx_space_above;
        set_vec[eisl_pkg::BIT_TX_STATUS_FULL]   = events.tx_status_full;
        set_vec[eisl_pkg::BIT_TX_STATUS_LEVEL]  = events.tx_status_level;
        set_vec[eisl_pkg::BIT_RX_FRAME_DROPPED] = events.rx_frame_dropped;
        set_vec[eisl_pkg::BIT_RX_DATA_LEVEL]    = events.rx_data_level;
        set_vec[eisl_pkg::BIT_RX_STATUS_FULL]   = events.rx_status_full;
        set_vec[eisl_pkg::BIT_RX_STATUS_LEVEL]  = events.rx_status_level;
        set_vec[2:0]                            = events.general_pin_irq;
    end

    // Write-one-to-clear vector, limited to sticky bits and enabled lanes
    assign clear_vec = (wr_access && paddr == eisl_pkg::ADDR_INTERRUPT_STATUS)
                     ? (pwdata & byte_mask & eisl_pkg::STICKY_MASK)
                     : 32'h00000000;

    // Read view: sticky flags plus live transceiver bit, reserved as zero
    always_comb begin
        status_view = state.flags & eisl_pkg::STICKY_MASK;
        status_view[eisl_pkg::BIT_TRANSCEIVER] = transceiver_event;
    end

    // Next state
    always_comb begin
        next_state = state;
        // Set wins over clear; mask plays no part in latching
        next_state.flags = ((state.flags & ~clear_vec) | set_vec)
                         & eisl_pkg::STICKY_MASK;
        if (wr_access && paddr == eisl_pkg::ADDR_SOFTWARE_IRQ_CTL && pstrb[3]) begin
            next_state.software_irq_enable = pwdata[eisl_pkg::BIT_SW_ENABLE];
        end
        // Only a byte test write wakes; power events leave awake alone
        if (wr_access && paddr == eisl_pkg::ADDR_BYTE_TEST) begin
            next_state.awake = 1'b1;
        end
        // Capture read data at the setup edge so the access phase shows a flop
        if (rd_setup) begin
            case (paddr)
                eisl_pkg::ADDR_INTERRUPT_STATUS: next_state.prdata = status_view;
                eisl_pkg::ADDR_SOFTWARE_IRQ_CTL: begin
                    next_state.prdata = 32'h00000000;
                    next_state.prdata[eisl_pkg::BIT_SW_ENABLE] = state.software_irq_enable;
                end
                eisl_pkg::ADDR_BYTE_TEST:   next_state.prdata = eisl_pkg::BYTE_TEST_VALUE;
                eisl_pkg::ADDR_WAKE_STATUS: next_state.prdata = {31'h00000000, state.awake};
                default:                    next_state.prdata = 32'h00000000;
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state.flags               <= eisl_pkg::RESET_FLAGS;
            state.software_irq_enable <= 1'b0;
            state.awake               <= 1'b0;
            state.prdata              <= 32'h00000000;
        end else begin
            state <= next_state;
        end
    end

    // Read data: registered word, shown only in the access cycle of a read
    always_comb begin
        prdata = 32'h00000000;
        if (rd_access) begin
            prdata = state.prdata;
        end
    end

    // Outputs to the enable mask and pin logic outside; power flag has no hold-off
    assign interrupt_status = status_view;
    assign power_event_flag = state.flags[eisl_pkg::BIT_POWER_EVENT];
    assign awake            = state.awake;

endmodule

`default_nettype wire

// File: sim/eisl_status_latch_asserts.sv
// Assertion checker for the interrupt status latch
`timescale 1ns/1ps
`default_nettype none
module eisl_chk (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [7:0]             paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [3:0]             pstrb,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic [31:0]            prdata,
    input wire eisl_pkg::eisl_events_t events,
    input wire logic                   transceiver_event,
    input wire logic [31:0]            interrupt_status,
    input wire logic                   power_event_flag,
    input wire logic                   awake
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Write access phase to the status word
    sequence wr_stat;
        psel && penable && pwrite && paddr == 8'h58;
    endsequence
    chk_clear_one: assert property (wr_stat ##0 (pwdata[6] && pstrb[0]
        && !events.rx_frame_dropped) |=> !interrupt_status[6]) else $error("flag kept");
    chk_set_wins: assert property (events.rx_error |=> interrupt_status[14])
        else $error("error flag not set");
    chk_flag_holds: assert property (interrupt_status[13] && !(psel && penable
        && pwrite && paddr == 8'h58 && pwdata[13] && pstrb[1]) |=> interrupt_status[13])
        else $error("flag lost");
    chk_phy_live: assert property (interrupt_status[18] == transceiver_event)
        else $error("phy view wrong");
    chk_reserved_zero: assert property ({interrupt_status[30:26], interrupt_status[22],
        interrupt_status[12]} == 7'h00) else $error("reserved bit set");
    chk_drop_half: assert property (events.drop_count_step
        && events.drop_count_prev == 32'h7fffffff |=> interrupt_status[23])
        else $error("halfway flag missing");
    chk_timer_wrap: assert property (events.timer_step && events.timer_prev == 16'h0000
        |=> interrupt_status[19]) else $error("timer flag missing");
    chk_power_out: assert property (power_event_flag == interrupt_status[17])
        else $error("power flag differs");
    chk_wake_write: assert property (psel && penable && pwrite && paddr == 8'h64
        |=> awake) else $error("no wake");
    chk_pin_latch: assert property (events.general_pin_irq[2] |=> interrupt_status[2])
        else $error("pin flag missing");
endmodule
bind eisl_status_latch eisl_chk u_eisl_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .pslverr, .prdata, .events, .transceiver_event,
    .interrupt_status, .power_event_flag, .awake);
`default_nettype wire

// File: sim/eisl_status_latch_test.sv
// Self-checking bench for the interrupt status latch
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ethernet_irq_status_latch_test;
    logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic                   transceiver_event, power_event_flag, awake;
    logic [7:0]             paddr;
    logic [3:0]             pstrb;
    logic [31:0]            pwdata, prdata, interrupt_status, rd;
    eisl_pkg::eisl_events_t events, e;
    int                     bad_count, comparisons, cyc;
    eisl_status_latch u_eisl_status_latch (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pstrb, .pready, .pslverr, .prdata, .events, .transceiver_event,
        .interrupt_status, .power_event_flag, .awake);
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // One APB transfer, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, 4'hf);
        `CHK(rd, x)
    endtask
    // One-cycle event strobe
    task automatic pulse(input eisl_pkg::eisl_events_t v);
        events <= v;
        @(posedge pclk);
        events <= '0;
        @(posedge pclk);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        cyc = 0;
        forever begin
            @(posedge pclk);
            cyc++;
            if (cyc >= 3000) begin
                bad_count++;
                end_sim();
            end
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, transceiver_event} = '0;
        {paddr, pstrb, pwdata, bad_count, comparisons} = '0;
        events = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(8'h58, 32'h0);
        rdchk(8'h64, 32'h87654321);
        $display("test reset done");
        // Every event at once, then partial and zero writes
        e = '1;
        e.drop_count_prev = 32'h7fffffff;
        e.timer_prev = 16'h0000;
        pulse(e);
        rdchk(8'h58, 32'h03bbefff);
        apb(1'b1, 8'h58, 32'hffffffff, 4'h1);
        rdchk(8'h58, 32'h03bbef00);
        wr(8'h58, 32'h0);
        rdchk(8'h58, 32'h03bbef00);
        wr(8'h58, 32'hffffffff);
        rdchk(8'h58, 32'h0);
        // Counter steps that are not the crossing
        e = '0;
        {e.drop_count_step, e.timer_step} = 2'b11;
        e.drop_count_prev = 32'h7ffffffe;
        e.timer_prev = 16'h0001;
        pulse(e);
        rdchk(8'h58, 32'h0);
        $display("test flags done");
        // Event during clearing write, and live transceiver bit
        e = '0;
        e.rx_error = 1'b1;
        events <= e;
        transceiver_event <= 1'b1;
        wr(8'h58, 32'hffffffff);
        events <= '0;
        rdchk(8'h58, 32'h00044000);
        transceiver_event <= 1'b0;
        wr(8'h58, 32'hffffffff);
        rdchk(8'h58, 32'h0);
        $display("test set wins done");
        // Software flag follows its enable
        wr(8'h5c, 32'h80000000);
        rdchk(8'h5c, 32'h80000000);
        rdchk(8'h58, 32'h80000000);
        wr(8'h5c, 32'h0);
        wr(8'h58, 32'h80000000);
        rdchk(8'h58, 32'h0);
        $display("test software done");
        // Power event does not wake; byte test write does
        e = '0;
        e.power_event = 1'b1;
        pulse(e);
        `CHK(power_event_flag, 1'b1)
        rdchk(8'h80, 32'h0);
        wr(8'h64, 32'h0);
        `CHK(awake, 1'b1)
        rdchk(8'h64, 32'h87654321);
        wr(8'h58, 32'h00020000);
        `CHK(power_event_flag, 1'b0)
        $display("test power done");
        // Unmapped address
        apb(1'b0, 8'h10, 32'h0, 4'hf);
        `CHK({err, rd}, 33'h100000000)
        $display("test unmapped done");
        end_sim();
    end
endmodule
`default_nettype wire
